// File: hw/pwm_pkg.sv
// Constants, register map and duty decode shared by the dual PWM block
package pwm_pkg;

  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 3;
  localparam int PINS        = 2;

  // Register word addresses
  localparam logic [2:0] REG_DUTY0   = 3'h0;
  localparam logic [2:0] REG_DUTY1   = 3'h1;
  localparam logic [2:0] REG_LATCH   = 3'h2;
  localparam logic [2:0] REG_DIR     = 3'h3;
  localparam logic [2:0] REG_PINS    = 3'h4;
  localparam logic [2:0] REG_COUNT   = 3'h5;

  // Reset values; direction resets to input so no pin drives out of reset
  localparam logic [7:0] DUTY_RESET  = 8'h00;
  localparam logic [1:0] LATCH_RESET = 2'h0;
  localparam logic [1:0] DIR_RESET   = 2'h3;
  localparam logic [7:0] READ_IDLE   = 8'h00;

  // Duty field layout and counter layout
  localparam int COARSE_LSB   = 2;
  localparam int COARSE_W     = 6;
  localparam int FINE_W       = 2;
  localparam int SUB_LSB      = 6;
  localparam int SUB_W        = 2;
  localparam int CYCLE_CLOCKS = 256;
  localparam int SUB_CLOCKS   = 64;
  localparam int COUNT_W      = $clog2(CYCLE_CLOCKS);
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_LAST  = 8'hff;
  localparam logic [7:0] COUNT_STEP  = 8'h01;
  localparam logic [5:0] SUB_FIRST   = 6'h00;
  localparam logic [5:0] SUB_LAST    = 6'h3f;

  // High or low for one clock of the modulation cycle
  function automatic logic high_at(input logic [7:0] duty, input logic [7:0] count);
    logic [6:0] limit;
    logic [6:0] pos;
    limit = {1'b0, duty[COARSE_LSB +: COARSE_W]};
    if (count[SUB_LSB +: SUB_W] < duty[FINE_W-1:0]) begin
      limit = limit + 7'h01;
    end
    pos = {1'b0, count[SUB_LSB-1:0]};
    return pos < limit;
  endfunction

endpackage

// File: hw/pwm_channel.sv
// One PWM channel: duty held for a full cycle, registered waveform
`timescale 1ns/10ps
module pwm_channel (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] count,
  input  wire logic [7:0] duty,
  output logic            wave,
  output logic [7:0]      active_duty
);

  logic       next_wave;
  logic [7:0] next_active_duty;

  always_comb begin
    next_active_duty = active_duty;
    // Reload only on the last clock so a cycle never mixes two values
    if (count == pwm_pkg::COUNT_LAST) begin
      next_active_duty = duty;
    end
    next_wave = pwm_pkg::high_at(active_duty, count);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_duty <= pwm_pkg::DUTY_RESET;
      wave        <= 1'b0;
    end else begin
      active_duty <= next_active_duty;
      wave        <= next_wave;
    end
  end

endmodule

// File: hw/pwm_pin_mux.sv
// Pin sharing between PWM waveform and plain port output
`timescale 1ns/10ps
module pwm_pin_mux (
  input  wire logic pwm_sel,
  input  wire logic pull_sel,
  input  wire logic dir,
  input  wire logic latch,
  input  wire logic wave,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      pullup_en
);

  always_comb begin
    pin_oe_n  = dir;
    pullup_en = pull_sel & dir;
    if (pwm_sel) begin
      pin_out = latch & wave;
    end else begin
      pin_out = latch;
    end
  end

endmodule

// File: hw/dual_pwm.sv
// Dual 6+2 PWM with port data and direction registers
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
//
// Contract
// - Two channels, each with its own software-written 8-bit duty register.
// - One cycle is 256 clocks, four sub-cycles of 64 clocks each.
// - Counter advances on every system clock, no prescaler.
// - Duty bits 7..2 are coarse value, bits 1..0 the extra-clock count.
// - Sub-cycle i high coarse+1 clocks if i below fine count, else coarse.
// - Pin carries PWM only when PWM option selected, else plain port.
// - Output, PWM selected, data bit 1: waveform passes to pin.
// - Data bit 0 disables PWM and drives pin low.
// - Direction bit 1 with PWM selected: pin is input, pull-high kept.
module dual_pwm (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [1:0] PWM_OPTION,
  input  wire logic [1:0] PULL_OPTION,
  input  wire logic [1:0] PIN_IN,
  output logic      [1:0] PIN_OUT,
  output logic      [1:0] PIN_OE_N,
  output logic      [1:0] PULLUP_EN
);

  logic [7:0] duty_reg_ch0;
  logic [7:0] duty_reg_ch1;
  logic [1:0] port_d_output_latch;
  logic [1:0] port_d_direction_ctrl;
  logic [7:0] count;
  logic [7:0] rdata;

  logic [7:0] next_duty_reg_ch0;
  logic [7:0] next_duty_reg_ch1;
  logic [1:0] next_port_d_output_latch;
  logic [1:0] next_port_d_direction_ctrl;
  logic [7:0] next_count;
  logic [7:0] next_rdata;

  // Option straps and pin levels arrive from outside the clock domain
  logic [1:0] opt_meta;
  logic [1:0] opt_sync;
  logic [1:0] pull_meta;
  logic [1:0] pull_sync;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] next_opt_meta;
  logic [1:0] next_opt_sync;
  logic [1:0] next_pull_meta;
  logic [1:0] next_pull_sync;
  logic [1:0] next_pin_meta;
  logic [1:0] next_pin_sync;

  logic [1:0] wave;
  logic [7:0] active_duty0;
  logic [7:0] active_duty1;

  always_comb begin
    next_opt_meta  = PWM_OPTION;
    next_opt_sync  = opt_meta;
    next_pull_meta = PULL_OPTION;
    next_pull_sync = pull_meta;
    next_pin_meta  = PIN_IN;
    next_pin_sync  = pin_meta;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      opt_meta  <= 2'h0;
      opt_sync  <= 2'h0;
      pull_meta <= 2'h0;
      pull_sync <= 2'h0;
      pin_meta  <= 2'h0;
      pin_sync  <= 2'h0;
    end else begin
      opt_meta  <= next_opt_meta;
      opt_sync  <= next_opt_sync;
      pull_meta <= next_pull_meta;
      pull_sync <= next_pull_sync;
      pin_meta  <= next_pin_meta;
      pin_sync  <= next_pin_sync;
    end
  end

  // Free-running cycle counter, one step per system clock
  always_comb begin
    next_count = count + pwm_pkg::COUNT_STEP;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      count <= pwm_pkg::COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // Register writes
  always_comb begin
    next_duty_reg_ch0          = duty_reg_ch0;
    next_duty_reg_ch1          = duty_reg_ch1;
    next_port_d_output_latch   = port_d_output_latch;
    next_port_d_direction_ctrl = port_d_direction_ctrl;
    if (WR) begin
      case (ADDR)
        pwm_pkg::REG_DUTY0: begin
          next_duty_reg_ch0 = WDATA;
        end
        pwm_pkg::REG_DUTY1: begin
          next_duty_reg_ch1 = WDATA;
        end
        pwm_pkg::REG_LATCH: begin
          next_port_d_output_latch = WDATA[1:0];
        end
        pwm_pkg::REG_DIR: begin
          next_port_d_direction_ctrl = WDATA[1:0];
        end
        default: begin
          next_duty_reg_ch0 = duty_reg_ch0;
        end
      endcase
    end
  end

  // Read data only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = pwm_pkg::READ_IDLE;
    if (RD) begin
      case (ADDR)
        pwm_pkg::REG_DUTY0: begin
          next_rdata = duty_reg_ch0;
        end
        pwm_pkg::REG_DUTY1: begin
          next_rdata = duty_reg_ch1;
        end
        pwm_pkg::REG_LATCH: begin
          next_rdata = {6'h00, port_d_output_latch};
        end
        pwm_pkg::REG_DIR: begin
          next_rdata = {6'h00, port_d_direction_ctrl};
        end
        pwm_pkg::REG_PINS: begin
          next_rdata = {6'h00, pin_sync};
        end
        pwm_pkg::REG_COUNT: begin
          next_rdata = count;
        end
        default: begin
          next_rdata = pwm_pkg::READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      duty_reg_ch0          <= pwm_pkg::DUTY_RESET;
      duty_reg_ch1          <= pwm_pkg::DUTY_RESET;
      port_d_output_latch   <= pwm_pkg::LATCH_RESET;
      port_d_direction_ctrl <= pwm_pkg::DIR_RESET;
      rdata                 <= pwm_pkg::READ_IDLE;
    end else begin
      duty_reg_ch0          <= next_duty_reg_ch0;
      duty_reg_ch1          <= next_duty_reg_ch1;
      port_d_output_latch   <= next_port_d_output_latch;
      port_d_direction_ctrl <= next_port_d_direction_ctrl;
      rdata                 <= next_rdata;
    end
  end

  assign RDATA = rdata;

  pwm_channel ch0 (
    .clk         (CLK),
    .rst         (RST),
    .count       (count),
    .duty        (duty_reg_ch0),
    .wave        (wave[0]),
    .active_duty (active_duty0)
  );

  pwm_channel ch1 (
    .clk         (CLK),
    .rst         (RST),
    .count       (count),
    .duty        (duty_reg_ch1),
    .wave        (wave[1]),
    .active_duty (active_duty1)
  );

  // Pin stays an input until software clears its direction bit
  pwm_pin_mux mux0 (
    .pwm_sel   (opt_sync[0]),
    .pull_sel  (pull_sync[0]),
    .dir       (port_d_direction_ctrl[0]),
    .latch     (port_d_output_latch[0]),
    .wave      (wave[0]),
    .pin_out   (PIN_OUT[0]),
    .pin_oe_n  (PIN_OE_N[0]),
    .pullup_en (PULLUP_EN[0])
  );

  pwm_pin_mux mux1 (
    .pwm_sel   (opt_sync[1]),
    .pull_sel  (pull_sync[1]),
    .dir       (port_d_direction_ctrl[1]),
    .latch     (port_d_output_latch[1]),
    .wave      (wave[1]),
    .pin_out   (PIN_OUT[1]),
    .pin_oe_n  (PIN_OE_N[1]),
    .pullup_en (PULLUP_EN[1])
  );

  // Expected levels, one clock ahead of the registered waveform
  logic expect0;
  logic expect1;
  always_comb begin
    expect0 = pwm_pkg::high_at(active_duty0, count);
    expect1 = pwm_pkg::high_at(active_duty1, count);
  end

  cycle_wrap_a: assert property (@(posedge CLK) disable iff (RST)
    count == pwm_pkg::COUNT_LAST |=> count == pwm_pkg::COUNT_RESET)
    else $error("cycle counter did not wrap after 256 clocks");

  sub_cycle_a: assert property (@(posedge CLK) disable iff (RST)
    count[5:0] == pwm_pkg::SUB_LAST |=>
      count[5:0] == pwm_pkg::SUB_FIRST && count[7:6] == $past(count[7:6]) + 2'h1)
    else $error("sub-cycle not 64 clocks long");

  no_prescale_a: assert property (@(posedge CLK) disable iff (RST)
    !$past(RST) |-> count == $past(count) + pwm_pkg::COUNT_STEP)
    else $error("counter skipped a system clock");

  duty_write_a: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == pwm_pkg::REG_DUTY1 |=> duty_reg_ch1 == $past(WDATA))
    else $error("duty write not stored");

  duty_hold_a: assert property (@(posedge CLK) disable iff (RST)
    count != pwm_pkg::COUNT_RESET |-> $stable(active_duty0) && $stable(active_duty1))
    else $error("duty changed inside a cycle");

  duty_load_a: assert property (@(posedge CLK) disable iff (RST)
    count == pwm_pkg::COUNT_LAST |=> active_duty0 == $past(duty_reg_ch0))
    else $error("duty not loaded at cycle start");

  ch1_load_a: assert property (@(posedge CLK) disable iff (RST)
    count == pwm_pkg::COUNT_LAST |=> active_duty1 == $past(duty_reg_ch1))
    else $error("second duty not loaded at cycle start");

  wave_shape_a: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> wave[0] == $past(expect0) && wave[1] == $past(expect1))
    else $error("waveform high time wrong");

  // Only a nonzero coarse field guarantees a high first clock in every sub-cycle
  wave_start_a: assert property (@(posedge CLK) disable iff (RST)
    count[5:0] == pwm_pkg::SUB_FIRST && active_duty0[7:2] != 6'h00 |=> wave[0])
    else $error("high time did not start at sub-cycle start");

  ch1_start_a: assert property (@(posedge CLK) disable iff (RST)
    count[5:0] == pwm_pkg::SUB_FIRST && active_duty1[7:2] != 6'h00 |=> wave[1])
    else $error("second high time did not start at sub-cycle start");

  wave_end_a: assert property (@(posedge CLK) disable iff (RST)
    count[5:0] == pwm_pkg::SUB_LAST && active_duty0[7:2] != 6'h3f |=> !wave[0])
    else $error("waveform high at end of short sub-cycle");

  ch1_end_a: assert property (@(posedge CLK) disable iff (RST)
    count[5:0] == pwm_pkg::SUB_LAST && active_duty1[7:2] != 6'h3f |=> !wave[1])
    else $error("second waveform high at end of short sub-cycle");

  pin_pass_a: assert property (@(posedge CLK) disable iff (RST)
    opt_sync[0] && !port_d_direction_ctrl[0] && port_d_output_latch[0] |->
      PIN_OUT[0] == wave[0] && !PIN_OE_N[0])
    else $error("PWM waveform not on pin");

  ch1_pass_a: assert property (@(posedge CLK) disable iff (RST)
    opt_sync[1] && !port_d_direction_ctrl[1] && port_d_output_latch[1] |->
      PIN_OUT[1] == wave[1] && !PIN_OE_N[1])
    else $error("second PWM waveform not on pin");

  pin_gate_a: assert property (@(posedge CLK) disable iff (RST)
    opt_sync[1] && !port_d_direction_ctrl[1] && !port_d_output_latch[1] |->
      !PIN_OUT[1] && !PIN_OE_N[1])
    else $error("gated PWM pin not driven low");

  ch0_gate_a: assert property (@(posedge CLK) disable iff (RST)
    opt_sync[0] && !port_d_direction_ctrl[0] && !port_d_output_latch[0] |->
      !PIN_OUT[0] && !PIN_OE_N[0])
    else $error("first gated PWM pin not driven low");

  pin_input_a: assert property (@(posedge CLK) disable iff (RST)
    port_d_direction_ctrl[0] |-> PIN_OE_N[0] && PULLUP_EN[0] == pull_sync[0])
    else $error("input pin driven or pull-high lost");

  ch1_input_a: assert property (@(posedge CLK) disable iff (RST)
    port_d_direction_ctrl[1] |-> PIN_OE_N[1] && PULLUP_EN[1] == pull_sync[1])
    else $error("second input pin driven or pull-high lost");

  plain_port_a: assert property (@(posedge CLK) disable iff (RST)
    !opt_sync[0] |-> PIN_OUT[0] == port_d_output_latch[0])
    else $error("unselected pin not plain port");

endmodule

// File: bench/pwm_load.sv
// Averaging load on the two PWM pins, with pad level resolution
`timescale 1ns/10ps
module pwm_load (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe_n,
  input  wire logic [1:0] pullup_en,
  input  wire logic [1:0] ext,
  output logic      [1:0] level,
  output logic      [8:0] avg0,
  output logic      [8:0] avg1
);
  logic [255:0] h0;
  logic [255:0] h1;

  // Released pin: pull-high wins, else the load's own level
  assign level = (~pin_oe_n & pin_out) | (pin_oe_n & (pullup_en | ext));
  // Sliding 256-clock window, so no alignment to the cycle start is needed
  assign avg0 = 9'($countones(h0));
  assign avg1 = 9'($countones(h1));

  always @(posedge clk) begin
    if (rst) begin
      h0 <= '0;
      h1 <= '0;
    end else begin
      h0 <= {h0[254:0], level[0]};
      h1 <= {h1[254:0], level[1]};
    end
  end
endmodule

// File: bench/dual_pwm_test.sv
// Self-checking bench for the dual PWM block
`timescale 1ns/10ps
`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module dual_pwm_test;
  logic       clk   = 1'b0;
  logic       rst   = 1'b1;
  logic [2:0] addr  = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic [1:0] opt   = 2'h3;
  logic [1:0] pull  = 2'h0;
  logic [1:0] ext   = 2'h0;
  logic       chk   = 1'b0;
  logic [7:0] rdata;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe_n;
  logic [1:0] pullup_en;
  logic [8:0] avg0;
  logic [8:0] avg1;
  logic [7:0] cnt;
  logic [7:0] sh0;
  logic [7:0] sh1;
  logic [7:0] act0;
  logic [7:0] act1;
  logic [1:0] lat;
  logic [1:0] dir;
  logic [1:0] wav;
  logic [7:0] duty [6] = '{8'h05, 8'hff, 8'h00, 8'h82, 8'h43, 8'hfe};
  int         n_errors = 0;
  int         checks   = 0;
  int         cyc      = 0;

  always #5 clk = ~clk;

  dual_pwm dut_u (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PWM_OPTION(opt), .PULL_OPTION(pull), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PULLUP_EN(pullup_en));

  pwm_load load_u (.clk(clk), .rst(rst), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .ext(ext), .level(pin_in), .avg0(avg0), .avg1(avg1));

  function automatic logic hi(input logic [7:0] d, input logic [7:0] c);
    return {1'b0, c[5:0]} < ({1'b0, d[7:2]} + 7'(c[7:6] < d[1:0]));
  endfunction

  // Reference: duty reloads only when the count wraps, wave lags one clock
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cnt <= rst ? 8'h00 : cnt + 8'h01;
    wav <= rst ? 2'h0 : {hi(act1, cnt), hi(act0, cnt)};
    if (rst) begin
      sh0 <= 8'h00;
      sh1 <= 8'h00;
      act0 <= 8'h00;
      act1 <= 8'h00;
      lat <= 2'h0;
      dir <= 2'h3;
    end else begin
      if (cnt == 8'hff) begin
        act0 <= sh0;
        act1 <= sh1;
      end
      if (wr) begin
        case (addr)
          pwm_pkg::REG_DUTY0: sh0 <= wdata;
          pwm_pkg::REG_DUTY1: sh1 <= wdata;
          pwm_pkg::REG_LATCH: lat <= wdata[1:0];
          pwm_pkg::REG_DIR: dir <= wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  always @(negedge clk) begin
    if (chk) begin
      `CHK(pin_out & ~dir, lat & (wav | ~opt) & ~dir)
      `CHK(pin_oe_n, dir)
      `CHK(pullup_en, pull & dir)
    end
  end

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // Option and pull inputs pass a synchroniser, so checks pause around them
  task automatic settle();
    repeat (4) @(posedge clk);
    chk <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] v;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wr_reg(3'h6, 8'hff);
    for (int a = 0; a < 8; a++) begin
      if (a != 4 && a != 5) begin
        rd_reg(3'(a), v);
        `CHK(v, (a == 3) ? {6'h00, pwm_pkg::DIR_RESET} : 8'h00)
      end
    end
    wr_reg(pwm_pkg::REG_DUTY0, 8'ha5);
    wr_reg(pwm_pkg::REG_DUTY1, 8'h3c);
    rd_reg(pwm_pkg::REG_DUTY0, v);
    `CHK(v, 8'ha5)
    rd_reg(pwm_pkg::REG_DUTY1, v);
    `CHK(v, 8'h3c)
    rd_reg(pwm_pkg::REG_COUNT, v);
    `CHK(v, cnt - 8'h01)
    $display("test registers done");
    wr_reg(pwm_pkg::REG_DIR, 8'h00);
    wr_reg(pwm_pkg::REG_LATCH, 8'h03);
    chk <= 1'b1;
    foreach (duty[i]) begin
      wr_reg(pwm_pkg::REG_DUTY0, duty[i]);
      wr_reg(pwm_pkg::REG_DUTY1, ~duty[i]);
      repeat (600) @(posedge clk);
      @(negedge clk);
      `CHK(avg0, {1'b0, duty[i]})
      `CHK(avg1, {1'b0, ~duty[i]})
    end
    $display("test waveforms done");
    wr_reg(pwm_pkg::REG_LATCH, 8'h01);
    repeat (300) @(negedge clk);
    `CHK(avg1, 9'h000)
    // Inputs move only just after a rising edge
    @(posedge clk);
    chk <= 1'b0;
    opt <= 2'h0;
    settle();
    repeat (300) @(negedge clk);
    `CHK(avg0, 9'h100)
    $display("test gating done");
    @(posedge clk);
    chk <= 1'b0;
    opt <= 2'h3;
    pull <= 2'h3;
    wr_reg(pwm_pkg::REG_DIR, 8'h03);
    settle();
    rd_reg(pwm_pkg::REG_PINS, v);
    `CHK(v, 8'h03)
    @(posedge clk);
    chk <= 1'b0;
    pull <= 2'h0;
    ext <= 2'h2;
    settle();
    rd_reg(pwm_pkg::REG_PINS, v);
    `CHK(v, 8'h02)
    $display("test input pins done");
    print_verdict();
  end
endmodule
